// File: src/dao_map.vh
// constants for the multiply block adder/output stage
// Notes on behaviour
// - stage works as product out, accumulator, 2-adder, 4-adder or 36-bit finisher
// - accumulator mode forces output registers on; optional elsewhere
// - stage only takes products from its own multiplier ports
// - narrow: four first-level adders, two summers; wide: two and one
// - two add/sub selects; narrow pairs top two and bottom two adders
// - add/sub select high adds, low subtracts
// - add/sub select delayed by zero, one or two register stages
// - sign controls shared with multipliers, up to two stages, same set
// - sign high means signed; product signed if either operand signed
// - products arrive full precision, width of both operands summed
// - accumulator feeds back its registered output; load replaces sum
// - accumulator load delayed by zero, one or two stages
// - overflow flag raised on accumulator overflow or underflow
// - wide: one summer of four products; narrow: two summers of four
// - output mux picks products, adder/accumulator or summation results
// - output registers use one of four clock/clear/enable sets
// - one operating mode per block at a time
// - simple mode passes four wide or eight narrow products
// - 36-bit mode combines four partials; product register is pipeline
// - 36-bit mode allows no input shift chaining
// - two accumulators on second and fourth products, 52 bits each
// - load and overflow act only in accumulate mode; subtract allowed
// - two-adder mode: two wide or four narrow pair sums
// - four-adder mode sums two first-level results; one width for all
`ifndef DAO_MAP_VH
`define DAO_MAP_VH
`define DAO_CTRL_OFS 8'h00
`define DAO_STAT_OFS 8'h04
`define DAO_CTRL_RST 16'h0000
`define DAO_F_MODE 2:0
`define DAO_F_NARROW 3
`define DAO_F_OREG 4
`define DAO_F_ASDLY 6:5
`define DAO_F_SGDLY 8:7
`define DAO_F_SLDLY 10:9
`define DAO_F_OSET 12:11
`define DAO_F_MSET 14:13
`define DAO_F_CHAIN 15
`define DAO_M_SIMPLE 3'h0
`define DAO_M_MAC 3'h1
`define DAO_M_ADD2 3'h2
`define DAO_M_ADD4 3'h3
`define DAO_M_M36 3'h4
`endif

// File: src/dao_dly.v
// control signal delay line of zero, one or two stages
`timescale 1ns/1ns
module dao_dly #(
    parameter W = 2
) (
    input wire clk,
    input wire rst_n,
    input wire en,
    input wire clr,
    input wire [1:0] depth,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end
        else if (clr)
        begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end
        else if (en)
        begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    always @*
    begin
        case (depth)
            2'd0: q = d;
            2'd1: q = s1_r;
            default: q = s2_r;
        endcase
    end
endmodule

// File: src/dao_asu.v
// first-level adder/subtractor of two products
`timescale 1ns/1ns
module dao_asu #(
    parameter W = 36,
    parameter OW = 37
) (
    input wire [W-1:0] a,
    input wire [W-1:0] b,
    input wire sgn,
    input wire add,
    output wire [OW-1:0] y
);
    wire [OW-1:0] ea;
    wire [OW-1:0] eb;

    assign ea = {{(OW-W){sgn & a[W-1]}}, a};
    assign eb = {{(OW-W){sgn & b[W-1]}}, b};
    assign y = add ? ea + eb : ea - eb;
endmodule

// File: src/dao_stage.v
// adder/output stage of the hard multiply block, with apb control
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "dao_map.vh"
module dao_stage (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [143:0] prod_i,
    input wire signa_i,
    input wire signb_i,
    input wire [1:0] addnsub_i,
    input wire [1:0] sload_i,
    input wire [3:0] ena_i,
    input wire [3:0] clr_i,
    output reg [143:0] res_o,
    output reg [1:0] ovf_o,
    output reg chain_en_o
);
    // ==========================================================
    // configuration register and apb slave
    // ==========================================================
    reg [15:0] ctrl_r;
    wire [2:0] mode;
    wire narrow;
    wire mac;
    wire oreg_on;
    wire [1:0] oset;
    wire [1:0] mset;
    wire setup;
    wire wr_acc;
    wire hit_ctrl;
    wire hit_stat;
    wire mode_ok;
    wire [2:0] wr_mode;

    assign mode = ctrl_r[`DAO_F_MODE];
    assign narrow = ctrl_r[`DAO_F_NARROW];
    assign mac = (mode == `DAO_M_MAC);
    assign oset = ctrl_r[`DAO_F_OSET];
    assign mset = ctrl_r[`DAO_F_MSET];
    assign oreg_on = ctrl_r[`DAO_F_OREG] | mac;

    assign setup = psel & ~penable;
    assign hit_ctrl = (paddr == `DAO_CTRL_OFS);
    assign hit_stat = (paddr == `DAO_STAT_OFS);
    assign wr_acc = psel & penable & pready & pwrite & hit_ctrl;
    assign wr_mode = pwdata[`DAO_F_MODE];
    // single mode field; undefined codes keep the old mode
    assign mode_ok = (wr_mode <= `DAO_M_M36);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= `DAO_CTRL_RST;
        end
        else if (wr_acc)
        begin
            ctrl_r <= {pwdata[15:3], mode_ok ? wr_mode : mode};
        end
    end

    // answer prepared in setup, so access ends in its first cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~hit_ctrl & ~hit_stat;
            if (setup & hit_ctrl)
            begin
                prdata <= {16'h0, ctrl_r};
            end
            else if (setup & hit_stat)
            begin
                prdata <= {25'h0, chain_en_o, oreg_on, mode, ovf_o};
            end
            else
            begin
                prdata <= 32'h0;
            end
        end
    end

    // no input chaining offered in 36-bit mode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chain_en_o <= 1'b0;
        end
        else
        begin
            chain_en_o <= ctrl_r[`DAO_F_CHAIN] & (mode != `DAO_M_M36);
        end
    end

    // ==========================================================
    // control delay lines
    // ==========================================================
    wire oen;
    wire oclr;
    wire [1:0] as_d;
    wire [1:0] sg_d;
    wire [1:0] sl_d;
    wire psgn;

    // output set chosen from four clock/clear/enable sets
    assign oen = oreg_on ? ena_i[oset] : 1'b1;
    assign oclr = oreg_on & clr_i[oset];

    dao_dly #(.W(2)) u_as (
        .clk(pclk),
        .rst_n(presetn),
        .en(ena_i[oset]),
        .clr(clr_i[oset]),
        .depth(ctrl_r[`DAO_F_ASDLY]),
        .d(addnsub_i),
        .q(as_d)
    );

    // sign controls on the multiplier set
    dao_dly #(.W(2)) u_sg (
        .clk(pclk),
        .rst_n(presetn),
        .en(ena_i[mset]),
        .clr(clr_i[mset]),
        .depth(ctrl_r[`DAO_F_SGDLY]),
        .d({signb_i, signa_i}),
        .q(sg_d)
    );

    dao_dly #(.W(2)) u_sl (
        .clk(pclk),
        .rst_n(presetn),
        .en(ena_i[oset]),
        .clr(clr_i[oset]),
        .depth(ctrl_r[`DAO_F_SLDLY]),
        .d(sload_i),
        .q(sl_d)
    );

    assign psgn = sg_d[0] | sg_d[1];

    // ==========================================================
    // first-level adders and summation
    // ==========================================================
    // the only data source is the multiplier product port
    wire [75:0] nsum;
    wire [73:0] wsum;
    wire [19:0] ns0;
    wire [19:0] ns1;
    wire [37:0] ws;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_lvl1
            // top pair on select 0, bottom pair on 1
            dao_asu #(.W(18), .OW(19)) u_n (
                .a(prod_i[36*i +: 18]),
                .b(prod_i[36*i+18 +: 18]),
                .sgn(psgn),
                .add(as_d[i/2]),
                .y(nsum[19*i +: 19])
            );
            if (i < 2)
            begin : g_wide
                // two wide adders, one select each
                dao_asu #(.W(36), .OW(37)) u_w (
                    .a(prod_i[72*i +: 36]),
                    .b(prod_i[72*i+36 +: 36]),
                    .sgn(psgn),
                    .add(as_d[i]),
                    .y(wsum[37*i +: 37])
                );
            end
        end
    endgenerate

    // one wide summer, two narrow summers
    // unsigned pair sums carry out; only signed data sign-extends
    assign ns0 = {psgn & nsum[18], nsum[18:0]} +
        {psgn & nsum[37], nsum[37:19]};
    assign ns1 = {psgn & nsum[56], nsum[56:38]} +
        {psgn & nsum[75], nsum[75:57]};
    assign ws = {psgn & wsum[36], wsum[36:0]} +
        {psgn & wsum[73], wsum[73:37]};

    // ==========================================================
    // accumulators
    // ==========================================================
    wire [105:0] acc_nxt;
    wire [1:0] acc_ovf;

    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_acc
            wire [35:0] p;
            wire [52:0] pe;
            wire [52:0] ae;
            wire [52:0] sum;
            // fed by second and fourth product slots
            assign p = prod_i[72*i+36 +: 36];
            assign pe = narrow ? {{35{psgn & p[17]}}, p[17:0]} :
                {{17{psgn & p[35]}}, p};
            // running sum from the registered output
            assign ae = {psgn & res_o[72*i+51], res_o[72*i +: 52]};
            // load only used in this mode; subtract also drives the first-level adders
            assign sum = sl_d[i] ? pe : (as_d[i] ? ae + pe : ae - pe);
            assign acc_nxt[53*i +: 53] = sum;
            // signed: top two differ; unsigned: carry or borrow
            assign acc_ovf[i] = ~sl_d[i] &
                (psgn ? (sum[52] ^ sum[51]) : sum[52]);
        end
    endgenerate

    // ==========================================================
    // 36-bit multiply finishing stage
    // ==========================================================
    reg [143:0] pipe_r;
    wire [71:0] m_p0;
    wire [71:0] m_p1;
    wire [71:0] m_p2;
    wire [71:0] m_p3;
    wire [71:0] m36;

    // product register reused as the pipeline stage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pipe_r <= 144'h0;
        end
        else if (oclr)
        begin
            pipe_r <= 144'h0;
        end
        else if (oen)
        begin
            pipe_r <= prod_i;
        end
    end

    // partials: lo*lo, hi_a*lo_b, lo_a*hi_b, hi*hi
    assign m_p0 = {36'h0, pipe_r[35:0]};
    assign m_p1 = {{18{sg_d[0] & pipe_r[71]}}, pipe_r[71:36], 18'h0};
    assign m_p2 = {{18{sg_d[1] & pipe_r[107]}}, pipe_r[107:72], 18'h0};
    assign m_p3 = {pipe_r[143:108], 36'h0};
    // shift and add of the four partials
    assign m36 = m_p0 + m_p1 + m_p2 + m_p3;

    // ==========================================================
    // output select and output registers
    // ==========================================================
    reg [143:0] sel_nxt;
    reg [1:0] ovf_nxt;

    always @*
    begin
        ovf_nxt = 2'b00;
        case (mode)
            `DAO_M_SIMPLE:
            begin
                sel_nxt = prod_i;
            end
            `DAO_M_MAC:
            begin
                sel_nxt = {20'h0, acc_nxt[104:53], 20'h0, acc_nxt[51:0]};
                ovf_nxt = acc_ovf;
            end
            `DAO_M_ADD2:
            begin
                if (narrow)
                begin
                    sel_nxt = {17'h0, nsum[75:57], 17'h0, nsum[56:38],
                        17'h0, nsum[37:19], 17'h0, nsum[18:0]};
                end
                else
                begin
                    sel_nxt = {35'h0, wsum[73:37], 35'h0, wsum[36:0]};
                end
            end
            `DAO_M_ADD4:
            begin
                // one width for all four, set by narrow bit
                if (narrow)
                begin
                    sel_nxt = {52'h0, ns1, 52'h0, ns0};
                end
                else
                begin
                    sel_nxt = {106'h0, ws};
                end
            end
            `DAO_M_M36:
            begin
                sel_nxt = {72'h0, m36};
            end
            default:
            begin
                sel_nxt = prod_i;
            end
        endcase
    end

    // bypassed registers still capture every cycle, so one flop stays in the path
    // clear and enable from the chosen set
    // overflow follows each update, not sticky; held only while enable is low
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_o <= 144'h0;
            ovf_o <= 2'b00;
        end
        else if (oclr)
        begin
            res_o <= 144'h0;
            ovf_o <= 2'b00;
        end
        else if (oen)
        begin
            res_o <= sel_nxt;
            ovf_o <= ovf_nxt;
        end
    end
endmodule

// File: verif/dao_stage_props.sv
// assertion checker for the multiply block adder/output stage
`timescale 1ns/1ns
`include "dao_map.vh"
module dao_stage_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [143:0] prod_i,
    input wire signa_i,
    input wire signb_i,
    input wire [1:0] addnsub_i,
    input wire [1:0] sload_i,
    input wire [3:0] ena_i,
    input wire [3:0] clr_i,
    input wire [143:0] res_o,
    input wire [1:0] ovf_o,
    input wire chain_en_o
);
    // ====================
    // control word shadow
    reg [15:0] ctl_r;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_r <= `DAO_CTRL_RST;
        // undefined mode codes leave the old mode in place
        else if (psel && penable && pready && pwrite &&
            paddr == `DAO_CTRL_OFS)
            ctl_r <= {pwdata[15:3], (pwdata[2:0] <= `DAO_M_M36) ?
                pwdata[2:0] : ctl_r[2:0]};
    end
    wire [2:0] md = ctl_r[2:0];
    wire [1:0] os = ctl_r[12:11];
    wire [35:0] s0 = prod_i[35:0];
    wire [35:0] s1 = prod_i[71:36];
    wire [35:0] s2 = prod_i[107:72];
    wire [35:0] s3 = prod_i[143:108];
    // only unsigned wide data with no control delay is modelled
    wire base = !signa_i && !signb_i && ctl_r[10:5] == 6'h00 && !ctl_r[3];
    wire pass = base && !ctl_r[4];
    wire regd = ctl_r[4] || md == `DAO_M_MAC;
    wire mac = base && md == `DAO_M_MAC && ena_i[os] && !clr_i[os];
    wire [36:0] r0 = addnsub_i[0] ? s0 + s1 : s0 - s1;
    wire [36:0] r1 = addnsub_i[1] ? s2 + s3 : s2 - s3;
    wire [37:0] r4 = s0 + s1 + s2 + s3;
    wire [52:0] a0 = addnsub_i[0] ? res_o[51:0] + s1 : res_o[51:0] - s1;
    wire [71:0] m36 = s0 + (s1 << 18) + (s2 << 18) + (s3 << 36);
    // ====================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_simple;
        pass && md == `DAO_M_SIMPLE |=> res_o == $past(prod_i);
    endproperty
    a_simple: assert property (p_simple) else $error("pass");
    property p_add2;
        pass && md == `DAO_M_ADD2
        |=> res_o == {35'h0, $past(r1), 35'h0, $past(r0)};
    endproperty
    a_add2: assert property (p_add2) else $error("add2");
    property p_add4;
        pass && md == `DAO_M_ADD4 && addnsub_i == 2'b11
        |=> res_o == {106'h0, $past(r4)};
    endproperty
    a_add4: assert property (p_add4) else $error("add4");
    property p_load;
        mac && sload_i[0] |=> res_o[51:0] == $past(s1) && !ovf_o[0];
    endproperty
    a_load: assert property (p_load) else $error("load");
    property p_acc;
        mac && !sload_i[0]
        |=> res_o[51:0] == $past(a0[51:0]) && ovf_o[0] == $past(a0[52]);
    endproperty
    a_acc: assert property (p_acc) else $error("acc");
    property p_hold;
        regd && !ena_i[os] && !clr_i[os] |=> $stable(res_o) && $stable(ovf_o);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_clr;
        regd && clr_i[os] |=> res_o == 144'h0 && ovf_o == 2'b00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_ovf0;
        md != `DAO_M_MAC && !ctl_r[4] |=> ovf_o == 2'b00;
    endproperty
    a_ovf0: assert property (p_ovf0) else $error("ovf");
    sequence s_ctl;
        (ctl_r[15] || md == `DAO_M_M36) ##1 $stable(ctl_r);
    endsequence
    property p_chain;
        s_ctl |-> chain_en_o == (md != `DAO_M_M36);
    endproperty
    a_chain: assert property (p_chain) else $error("chain");
    sequence s_m36;
        pass && md == `DAO_M_M36 ##1 md == `DAO_M_M36;
    endsequence
    property p_m36;
        s_m36 |=> res_o == {72'h0, $past(m36, 2)};
    endproperty
    a_m36: assert property (p_m36) else $error("m36");
endmodule
bind dao_stage dao_stage_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prod_i(prod_i), .signa_i(signa_i), .signb_i(signb_i),
    .addnsub_i(addnsub_i), .sload_i(sload_i), .ena_i(ena_i),
    .clr_i(clr_i), .res_o(res_o), .ovf_o(ovf_o), .chain_en_o(chain_en_o)
);

// File: verif/dao_ovf_hold.sv
// fabric-side holder that keeps accumulator overflow once seen
`timescale 1ns/1ns
module dao_ovf_hold (
    input wire pclk,
    input wire presetn,
    input wire clr,
    input wire [1:0] ovf,
    output reg [1:0] held_r
);
    // ====================
    // sticky capture
    // fabric holds overflow
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            held_r <= 2'b00;
        else
            held_r <= clr ? 2'b00 : held_r | ovf;
    end
endmodule

// File: verif/dsp_adder_output_stage_test.sv
// self-checking bench for the multiply block adder/output stage
`timescale 1ns/1ns
`include "dao_map.vh"
module dsp_adder_output_stage_test;
    reg pclk, presetn, psel, penable, pwrite, signa_i, signb_i, hold_clr;
    reg [7:0] paddr;
    reg [31:0] pwdata, rdat;
    reg [143:0] prod_i;
    reg [1:0] addnsub_i, sload_i;
    reg [3:0] ena_i, clr_i;
    wire [31:0] prdata;
    wire pready, pslverr, chain_en_o;
    wire [143:0] res_o;
    wire [1:0] ovf_o, held;
    reg rerr;
    reg [35:0] s0, s1, s2, s3, ax, bx;
    reg [37:0] t;
    reg [51:0] a0, a1;
    reg [71:0] pr;
    integer bad_count, checks_done, i;
    dao_stage DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prod_i(prod_i),
        .signa_i(signa_i), .signb_i(signb_i), .addnsub_i(addnsub_i),
        .sload_i(sload_i), .ena_i(ena_i), .clr_i(clr_i), .res_o(res_o),
        .ovf_o(ovf_o), .chain_en_o(chain_en_o)
    );
    dao_ovf_hold u_hold (
        .pclk(pclk), .presetn(presetn), .clr(hold_clr), .ovf(ovf_o),
        .held_r(held)
    );
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ====================
    // tasks
    task chk(input [143:0] got, input [143:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        integer n;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    end
    endtask
    // one capture edge with enable, then a held edge, then look
    task op(input [143:0] p, input [1:0] as, input [1:0] sl);
    begin
        @(posedge pclk);
        prod_i <= p;
        addnsub_i <= as;
        sload_i <= sl;
        ena_i <= 4'hf;
        @(posedge pclk);
        ena_i <= 4'h0;
        @(posedge pclk);
        @(negedge pclk);
    end
    endtask
    function [36:0] add37(input [35:0] x, input [35:0] y, input up);
        add37 = up ? x + y : x - y;
    endfunction
    // ====================
    // main sequence
    initial
    begin
        bad_count = 0;
        checks_done = 0;
        presetn = 1'b0;
        hold_clr = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
        {signa_i, signb_i, addnsub_i, sload_i, ena_i, clr_i} = 14'h0;
        prod_i = 144'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(`DAO_CTRL_OFS, 1'b0, 32'h0);
        chk(rdat, `DAO_CTRL_RST);
        apb(`DAO_STAT_OFS, 1'b1, 32'hffff_ffff);
        apb(`DAO_STAT_OFS, 1'b0, 32'h0);
        chk(rdat, 32'h0);
        apb(8'h08, 1'b1, 32'h1);
        chk({rerr, rdat}, {1'b1, 32'h0});
        $display("test registers done");
        s0 = 36'h8_0000_0003;
        s1 = 36'hc_0000_0001;
        s2 = 36'h1_2345_6789;
        s3 = 36'hf_edcb_a987;
        op({s3, s2, s1, s0}, 2'b11, 2'b00);
        chk(res_o, {s3, s2, s1, s0});
        apb(`DAO_CTRL_OFS, 1'b1, {29'h0, `DAO_M_ADD2});
        for (i = 0; i < 4; i = i + 1)
        begin
            op({s3, s2, s1, s0}, i[1:0], 2'b00);
            chk(res_o, {35'h0, add37(s2, s3, i[1]), 35'h0,
                add37(s0, s1, i[0])});
        end
        // registered outputs, select one stage late: second op subtracts
        apb(`DAO_CTRL_OFS, 1'b1, 32'h0000_0032);
        op({s3, s2, s1, s0}, 2'b00, 2'b00);
        op({s3, s2, s1, s0}, 2'b11, 2'b00);
        chk(res_o, {35'h0, add37(s2, s3, 1'b0), 35'h0,
            add37(s0, s1, 1'b0)});
        apb(`DAO_CTRL_OFS, 1'b1, {29'h0, `DAO_M_ADD4});
        op({s3, s2, s1, s0}, 2'b11, 2'b00);
        t = s0 + s1 + s2 + s3;
        chk(res_o, {106'h0, t});
        op({72'h0, s1, s0}, 2'b11, 2'b00);
        chk(res_o, {106'h0, 38'h14_0000_0004});
        @(posedge pclk);
        signa_i <= 1'b1;
        op({4{36'hf_ffff_ffff}}, 2'b11, 2'b00);
        chk(res_o, {106'h0, 38'h3f_ffff_fffc});
        @(posedge pclk);
        signa_i <= 1'b0;
        $display("test adders done");
        apb(`DAO_CTRL_OFS, 1'b1, {29'h0, `DAO_M_MAC});
        op({36'h3, s2, 36'h1, s0}, 2'b11, 2'b11);
        a0 = 52'h1;
        a1 = 52'h3;
        chk(res_o, {20'h0, a1, 20'h0, a0});
        op({36'h6, s2, 36'h5, s0}, 2'b11, 2'b00);
        a0 = a0 + 52'h5;
        a1 = a1 + 52'h6;
        chk(res_o, {20'h0, a1, 20'h0, a0});
        op({36'h1, s2, 36'h7, s0}, 2'b10, 2'b00);
        a0 = a0 - 52'h7;
        a1 = a1 + 52'h1;
        chk(res_o, {20'h0, a1, 20'h0, a0});
        chk(ovf_o, 2'b01);
        apb(`DAO_STAT_OFS, 1'b0, 32'h0);
        chk(rdat, 32'h25);
        op({36'h0, s2, 36'h0, s0}, 2'b11, 2'b00);
        chk(ovf_o, 2'b00);
        chk(held, 2'b01);
        @(posedge pclk);
        clr_i <= 4'h1;
        hold_clr <= 1'b1;
        @(posedge pclk);
        clr_i <= 4'h0;
        hold_clr <= 1'b0;
        @(negedge pclk);
        chk(res_o, 144'h0);
        chk(held, 2'b00);
        $display("test accumulate done");
        apb(`DAO_CTRL_OFS, 1'b1, 32'h0000_8004);
        ax = {18'h2_0001, 18'h3_ffff};
        bx = {18'h3_0f0f, 18'h1_2345};
        s0 = ax[17:0] * bx[17:0];
        s1 = ax[35:18] * bx[17:0];
        s2 = ax[17:0] * bx[35:18];
        s3 = ax[35:18] * bx[35:18];
        pr = ax * bx;
        op({s3, s2, s1, s0}, 2'b11, 2'b00);
        chk(res_o, {72'h0, pr});
        chk(chain_en_o, 1'b0);
        apb(`DAO_CTRL_OFS, 1'b1, 32'h0000_8008);
        op({s3, s2, s1, s0}, 2'b11, 2'b00);
        chk(res_o, {s3, s2, s1, s0});
        chk(chain_en_o, 1'b1);
        // undefined mode code must leave simple mode in place
        apb(`DAO_CTRL_OFS, 1'b1, 32'h0000_0007);
        apb(`DAO_CTRL_OFS, 1'b0, 32'h0);
        chk(rdat, 32'h0);
        $display("test wide multiply done");
        final_report;
    end
endmodule
